// ### rtl/i2sap_port.sv
// Stereo serial audio port, master or slave, with system and link clock domains.
// Functional notes
// - Master drives bit clock and word select; slave takes both from outside.
// - Serial data output is always an output in both modes.
// - Left and right channel words are sixteen bits each.
// - Left word most significant bit sits in the first data bit position.
// - Word most significant bit follows each word-select change by one bit period.
// - Transmitted data bits change on the falling bit clock edge.
// - Left data while word select is low, right while it is high.
// - Port and PCM share hardware; enabling one excludes the other.
`timescale 1ns/1ns
module i2sap_port (
  input  wire logic        clk_sys_in,
  input  wire logic        srst_in,
  input  wire logic        clk_link_in,
  input  wire logic        i2s_en_in,
  input  wire logic        pcm_en_in,
  input  wire logic        master_in,
  input  wire logic        tx_valid_in,
  input  wire logic [15:0] tx_left_in,
  input  wire logic [15:0] tx_right_in,
  input  wire logic        sck_in,
  input  wire logic        ws_in,
  input  wire logic        din_in,
  output logic             tx_ready_out,
  output logic             rx_valid_out,
  output logic      [15:0] rx_left_out,
  output logic      [15:0] rx_right_out,
  output logic             i2s_active_out,
  output logic             pcm_allow_out,
  output logic             sck_out,
  output logic             sck_oe_out,
  output logic             ws_out,
  output logic             ws_oe_out,
  output logic             dout_out
);
  // System-domain state.
  logic        active_d, pcm_ok_d, full_q, full_d, rdy_d, req_q, req_d;
  logic        seen_q, seen_d, rxv_d;
  logic [15:0] hold_l_q, hold_l_d, hold_r_q, hold_r_d, rxo_l_d, rxo_r_d;
  logic        ack_s, rxt_s;

  // Link-domain state.
  i2sap_pkg::i2sap_mode_t mode_q, mode_d;
  logic [1:0]  div_q, div_d;
  logic [4:0]  slot_q, slot_d;
  logic        sck_q, sck_d, sck_prev_q, sck_prev_d, ws_q, ws_d, dout_q, dout_d;
  logic        oe_q, oe_d, ack_q, ack_d, rxt_q, rxt_d, fall, rise;
  logic [15:0] tx_l_q, tx_l_d, tx_r_q, tx_r_d, rx_sh_q, rx_sh_d;
  logic [15:0] rx_l_q, rx_l_d, rx_r_q, rx_r_d, shifted;
  logic        rst_l, act_s, mst_s, req_s, sck_s, ws_s, din_s;

  // Crossings: reset and controls into the link domain, toggles back out.
  i2sap_sync #(.W(1)) u_rst (
    .clk_in  (clk_link_in),
    .srst_in (1'b0),
    .d_in    (srst_in),
    .q_out   (rst_l)
  );
  i2sap_sync #(.W(6)) u_link (
    .clk_in  (clk_link_in),
    .srst_in (rst_l),
    .d_in    ({i2s_active_out, master_in, req_q, sck_in, ws_in, din_in}),
    .q_out   ({act_s, mst_s, req_s, sck_s, ws_s, din_s})
  );
  i2sap_sync #(.W(2)) u_sys (
    .clk_in  (clk_sys_in),
    .srst_in (srst_in),
    .d_in    ({ack_q, rxt_q}),
    .q_out   ({ack_s, rxt_s})
  );

  // System side: grant of shared hardware, transmit holding pair, receive delivery.
  always_comb begin
    active_d = i2s_en_in & ~pcm_en_in;
    pcm_ok_d = ~i2s_en_in;
    full_d   = full_q;
    req_d    = req_q;
    hold_l_d = hold_l_q;
    hold_r_d = hold_r_q;
    if (full_q && (ack_s == req_q)) begin
      full_d = 1'b0;
    end
    if (!full_q && tx_valid_in) begin
      full_d   = 1'b1;
      req_d    = ~req_q;
      hold_l_d = tx_left_in;
      hold_r_d = tx_right_in;
    end
    rdy_d   = ~full_d;
    seen_d  = rxt_s;
    rxv_d   = rxt_s != seen_q;
    rxo_l_d = rxv_d ? rx_l_q : rx_left_out;
    rxo_r_d = rxv_d ? rx_r_q : rx_right_out;
  end

  // System-side registers.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      i2s_active_out <= 1'b0;
      pcm_allow_out  <= 1'b1;
      full_q         <= 1'b0;
      tx_ready_out   <= 1'b1;
      req_q          <= 1'b0;
      hold_l_q       <= '0;
      hold_r_q       <= '0;
      seen_q         <= 1'b0;
      rx_valid_out   <= 1'b0;
      rx_left_out    <= '0;
      rx_right_out   <= '0;
    end else begin
      i2s_active_out <= active_d;
      pcm_allow_out  <= pcm_ok_d;
      full_q         <= full_d;
      tx_ready_out   <= rdy_d;
      req_q          <= req_d;
      hold_l_q       <= hold_l_d;
      hold_r_q       <= hold_r_d;
      seen_q         <= seen_d;
      rx_valid_out   <= rxv_d;
      rx_left_out    <= rxo_l_d;
      rx_right_out   <= rxo_r_d;
    end
  end

  // Link side: bit clock generation or edge detection, framing, shifting.
  always_comb begin
    mode_d     = mode_q;
    div_d      = div_q;
    sck_d      = sck_q;
    sck_prev_d = sck_s;
    slot_d     = slot_q;
    ws_d       = ws_q;
    dout_d     = dout_q;
    tx_l_d     = tx_l_q;
    tx_r_d     = tx_r_q;
    ack_d      = ack_q;
    rx_sh_d    = rx_sh_q;
    rx_l_d     = rx_l_q;
    rx_r_d     = rx_r_q;
    rxt_d      = rxt_q;
    fall       = 1'b0;
    rise       = 1'b0;
    shifted    = {rx_sh_q[14:0], din_s};
    case (mode_q)
      i2sap_pkg::MODE_MASTER: begin
        div_d = div_q + i2sap_pkg::DIV_STEP;
        if (div_q == i2sap_pkg::DIV_LAST) begin
          sck_d = ~sck_q;
          fall  = sck_q;
          rise  = ~sck_q;
        end
      end
      i2sap_pkg::MODE_SLAVE: begin
        fall = sck_prev_q & ~sck_s;
        rise = ~sck_prev_q & sck_s;
      end
      default: begin
        fall = 1'b0;
      end
    endcase
    // Each falling edge advances the slot and drives the next bit.
    if (fall) begin
      slot_d = slot_q + i2sap_pkg::SLOT_STEP;
      if (mode_q == i2sap_pkg::MODE_MASTER) begin
        ws_d = (slot_d >= i2sap_pkg::SLOT_LEFT_LSB) &&
               (slot_d != i2sap_pkg::SLOT_RIGHT_LSB);
      end else begin
        ws_d = ws_s;
        if (ws_s != ws_q) begin
          slot_d = ws_s ? i2sap_pkg::SLOT_LEFT_LSB : i2sap_pkg::SLOT_RIGHT_LSB;
        end
      end
      dout_d = slot_d[4] ? tx_r_q[~slot_d[3:0]] : tx_l_q[~slot_d[3:0]];
      if (slot_d == i2sap_pkg::SLOT_RIGHT_LSB) begin
        tx_l_d = (req_s != ack_q) ? hold_l_q : '0;
        tx_r_d = (req_s != ack_q) ? hold_r_q : '0;
        ack_d  = req_s;
      end
    end
    // Each rising edge samples the input into the current slot.
    if (rise) begin
      rx_sh_d = shifted;
      if (slot_q == i2sap_pkg::SLOT_LEFT_LSB) begin
        rx_l_d = shifted;
      end
      if (slot_q == i2sap_pkg::SLOT_RIGHT_LSB) begin
        rx_r_d = shifted;
        rxt_d  = ~rxt_q;
      end
    end
    // Mode follows the synchronised controls and restarts the frame on change.
    if (!act_s) begin
      mode_d = i2sap_pkg::MODE_IDLE;
    end else if (mst_s) begin
      mode_d = i2sap_pkg::MODE_MASTER;
    end else begin
      mode_d = i2sap_pkg::MODE_SLAVE;
    end
    if (mode_d != mode_q) begin
      div_d  = '0;
      sck_d  = 1'b0;
      slot_d = i2sap_pkg::SLOT_RIGHT_LSB;
      ws_d   = 1'b0;
      dout_d = 1'b0;
    end
    oe_d = mode_d == i2sap_pkg::MODE_MASTER;
  end

  // Link-side registers.
  always_ff @(posedge clk_link_in) begin
    if (rst_l) begin
      mode_q     <= i2sap_pkg::MODE_IDLE;
      div_q      <= '0;
      sck_q      <= 1'b0;
      sck_prev_q <= 1'b0;
      slot_q     <= i2sap_pkg::SLOT_RIGHT_LSB;
      ws_q       <= 1'b0;
      dout_q     <= 1'b0;
      oe_q       <= 1'b0;
      tx_l_q     <= '0;
      tx_r_q     <= '0;
      ack_q      <= 1'b0;
      rx_sh_q    <= '0;
      rx_l_q     <= '0;
      rx_r_q     <= '0;
      rxt_q      <= 1'b0;
    end else begin
      mode_q     <= mode_d;
      div_q      <= div_d;
      sck_q      <= sck_d;
      sck_prev_q <= sck_prev_d;
      slot_q     <= slot_d;
      ws_q       <= ws_d;
      dout_q     <= dout_d;
      oe_q       <= oe_d;
      tx_l_q     <= tx_l_d;
      tx_r_q     <= tx_r_d;
      ack_q      <= ack_d;
      rx_sh_q    <= rx_sh_d;
      rx_l_q     <= rx_l_d;
      rx_r_q     <= rx_r_d;
      rxt_q      <= rxt_d;
    end
  end

  // Pins; the data output has no enable and is always driven.
  assign sck_out    = sck_q;
  assign sck_oe_out = oe_q;
  assign ws_out     = ws_q;
  assign ws_oe_out  = oe_q;
  assign dout_out   = dout_q;

  // Link-domain checks; a mode change may cut a high bit clock phase short.
  sequence master_fall_s;
    (mode_q == i2sap_pkg::MODE_MASTER) && fall;
  endsequence
  sequence msb_slot_s;
    master_fall_s ##0 (slot_d == '0);
  endsequence
  oe_master_a: assert property (@(posedge clk_link_in) disable iff (rst_l)
    (mode_q == i2sap_pkg::MODE_MASTER) |-> oe_q && ws_oe_out)
    else $error("pin enables low while in master mode");
  sck_half_a: assert property (@(posedge clk_link_in) disable iff (rst_l)
    (mode_q == i2sap_pkg::MODE_MASTER) && (mode_d == mode_q) && $rose(sck_q) |->
    (sck_q || (mode_q != i2sap_pkg::MODE_MASTER)) [*4])
    else $error("bit clock high phase shorter than four link cycles");
  dout_idle_a: assert property (@(posedge clk_link_in) disable iff (rst_l)
    (mode_q == i2sap_pkg::MODE_IDLE) && (mode_d == mode_q) |=> !dout_out)
    else $error("data output not held low while idle");
  msb_first_a: assert property (@(posedge clk_link_in) disable iff (rst_l)
    msb_slot_s |=> (dout_q == tx_l_q[15]))
    else $error("left word msb not driven in first slot");
  ws_lead_a: assert property (@(posedge clk_link_in) disable iff (rst_l)
    master_fall_s ##0 (ws_d != ws_q) |->
    (slot_d == i2sap_pkg::SLOT_LEFT_LSB) || (slot_d == i2sap_pkg::SLOT_RIGHT_LSB))
    else $error("word select changed away from the last bit of a word");
  dout_fall_a: assert property (@(posedge clk_link_in) disable iff (rst_l)
    !fall && (mode_d == mode_q) |=> $stable(dout_q))
    else $error("data output changed without a falling bit clock edge");
  ws_left_a: assert property (@(posedge clk_link_in) disable iff (rst_l)
    (mode_q == i2sap_pkg::MODE_MASTER) && (slot_q < i2sap_pkg::SLOT_LEFT_LSB) |-> !ws_q)
    else $error("word select high during left word");
  rx_frame_a: assert property (@(posedge clk_link_in) disable iff (rst_l)
    rise && (slot_q == i2sap_pkg::SLOT_RIGHT_LSB) |=> $changed(rxt_q) && (rx_r_q == rx_sh_q))
    else $error("right word not delivered after its sixteenth bit");

  // System-domain checks.
  grant_excl_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    pcm_en_in |=> !i2s_active_out ##1 !(i2s_active_out && pcm_allow_out))
    else $error("port and pcm granted together");
  rx_pulse_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    rx_valid_out |=> !rx_valid_out)
    else $error("receive valid longer than one cycle");
endmodule

// ### rtl/i2sap_pkg.sv
// Constants and types shared by the stereo serial audio port.
package i2sap_pkg;
  localparam int         WORD_BITS      = 16;
  localparam logic [4:0] SLOT_LEFT_LSB  = 5'h0f;
  localparam logic [4:0] SLOT_RIGHT_LSB = 5'h1f;
  localparam logic [1:0] DIV_LAST       = 2'h3;
  localparam logic [4:0] SLOT_STEP      = 5'h01;
  localparam logic [1:0] DIV_STEP       = 2'h1;

  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_MASTER,
    MODE_SLAVE
  } i2sap_mode_t;
endpackage

// ### rtl/i2sap_sync.sv
// Two-stage synchroniser for levels entering a clock domain.
`timescale 1ns/1ns
module i2sap_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule

// ### bench/i2sap_codec.sv
// Behavioural far-side audio codec for the serial audio port.
`timescale 1ns/1ns
module i2sap_codec #(
  parameter int HALF_NS = 512
) (
  input  wire logic        sck_in,
  input  wire logic        ws_in,
  input  wire logic        dout_in,
  input  wire logic        gen_en_in,
  input  wire logic [15:0] left_in,
  input  wire logic [15:0] right_in,
  output logic             sck_out,
  output logic             ws_out,
  output logic             din_out,
  output logic      [15:0] rx_left_out,
  output logic      [15:0] rx_right_out,
  output logic      [7:0]  frames_out
);
  logic [15:0] sh_q = 16'h0000;
  logic        ws_q = 1'b0;
  logic        ch_q = 1'b0;
  int          cnt = -1;
  initial begin
    {sck_out, ws_out, din_out} = 3'h0;
    {rx_left_out, rx_right_out, frames_out} = 40'h0;
  end
  // Acts as clock master in slave mode; the clock runs on from frame to frame without a pause while enabled.
  always begin
    wait (gen_en_in);
    for (int s = 0; s < 32; s++) begin
      #HALF_NS sck_out = 1'b0;
      ws_out = (s >= 15) && (s < 31);
      #HALF_NS sck_out = 1'b1;
    end
  end
  // Captures the port's data on rising edges and closes a word on each select change.
  always @(posedge sck_in) begin
    sh_q <= {sh_q[14:0], dout_in};
    ws_q <= ws_in;
    if (ws_in != ws_q) begin
      ch_q <= ws_in;
      cnt <= 15;
      if (ws_q) begin
        rx_right_out <= {sh_q[14:0], dout_in};
        frames_out <= frames_out + 8'h01;
      end else begin
        rx_left_out <= {sh_q[14:0], dout_in};
      end
    end
  end
  // Sends our words on falling edges; outside a word the line keeps changing.
  always @(negedge sck_in) begin
    if (cnt >= 0) begin
      din_out <= ch_q ? right_in[cnt] : left_in[cnt];
      cnt <= cnt - 1;
    end else begin
      din_out <= ~din_out;
    end
  end
endmodule

// ### bench/i2s_audio_port_tb_top.sv
// Self-checking testbench for the serial audio port.
`timescale 1ns/1ns
module i2s_audio_port_tb_top;
  logic        clk_sys_in = 1'b0;
  logic        clk_link = 1'b0;
  logic        srst_in = 1'b1;
  logic        en = 1'b0, pcm = 1'b0, mst = 1'b0, tv = 1'b0, gen = 1'b0;
  logic [15:0] tl = 16'h0000, tr = 16'h0000, cl = 16'h0000, cr = 16'h0000;
  logic        trdy, rxv, act, allow, sck, sck_oe, ws, ws_oe, dout, c_sck, c_ws, c_din;
  logic [15:0] rl, rr, cap_l, cap_r;
  logic [7:0]  frames;
  int          error_cnt = 0;
  int          cmp_count = 0;
  wire         sck_w = sck_oe ? sck : c_sck;
  wire         ws_w = ws_oe ? ws : c_ws;
  // Clocks: system 10 ns, link 64 ns with an unrelated phase.
  always #5 clk_sys_in = ~clk_sys_in;
  initial #7 forever #32 clk_link = ~clk_link;
  i2sap_port DUT (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .clk_link_in(clk_link),
    .i2s_en_in(en), .pcm_en_in(pcm), .master_in(mst), .tx_valid_in(tv), .tx_left_in(tl),
    .tx_right_in(tr), .sck_in(sck_w), .ws_in(ws_w), .din_in(c_din), .tx_ready_out(trdy),
    .rx_valid_out(rxv), .rx_left_out(rl), .rx_right_out(rr), .i2s_active_out(act),
    .pcm_allow_out(allow), .sck_out(sck), .sck_oe_out(sck_oe), .ws_out(ws),
    .ws_oe_out(ws_oe), .dout_out(dout));
  i2sap_codec codec (.sck_in(sck_w), .ws_in(ws_w), .dout_in(dout), .gen_en_in(gen),
    .left_in(cl), .right_in(cr), .sck_out(c_sck), .ws_out(c_ws), .din_out(c_din),
    .rx_left_out(cap_l), .rx_right_out(cap_r), .frames_out(frames));
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Waits for a number of completed frames at the codec, bounded.
  task automatic frames_wait(input int n);
    logic [7:0] f;
    f = frames;
    for (int i = 0; i < 20000; i++) begin
      @(posedge clk_sys_in);
      if (frames == f + 8'(n)) return;
    end
    error_cnt++;
    close_out();
  endtask
  // Waits for a received-pair pulse, bounded, then checks the pair.
  task automatic rx_check(input logic [15:0] l, input logic [15:0] r);
    for (int i = 0; i < 5000; i++) begin
      @(posedge clk_sys_in);
      #1;
      if (rxv === 1'b1) begin
        chk("rx_left", rl, l);
        chk("rx_right", rr, r);
        return;
      end
    end
    error_cnt++;
    close_out();
  endtask
  // Offers a pair and checks that the holding slot closes the next cycle.
  task automatic offer(input logic [15:0] l, input logic [15:0] r);
    @(posedge clk_sys_in);
    tv <= 1'b1;
    tl <= l;
    tr <= r;
    // Ready is looked at mid-cycle, so the next rising edge is the one that takes the pair.
    for (int i = 0; i < 5000; i++) begin
      @(negedge clk_sys_in);
      if (trdy === 1'b1) begin
        @(posedge clk_sys_in);
        #1 chk("ready_low", 16'(trdy), 16'h0000);
        return;
      end
    end
    error_cnt++;
    close_out();
  endtask
  // Grant logic: the PCM enable excludes the port and the port excludes PCM.
  task automatic t_grant();
    @(posedge clk_sys_in);
    en <= 1'b1;
    pcm <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    chk("active_both", 16'(act), 16'h0000);
    chk("allow_both", 16'(allow), 16'h0000);
    pcm <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    chk("active_port", 16'(act), 16'h0001);
    chk("allow_port", 16'(allow), 16'h0000);
  endtask
  // Master mode: port drives the clocks; both directions carry a full pair.
  task automatic t_master();
    mst <= 1'b1;
    cl <= 16'h8001;
    cr <= 16'h7ffe;
    offer(16'ha5c3, 16'h3c5a);
    frames_wait(3);
    chk("sck_oe_m", 16'(sck_oe), 16'h0001);
    chk("ws_oe_m", 16'(ws_oe), 16'h0001);
    chk("cap_left_m", cap_l, 16'ha5c3);
    chk("cap_right_m", cap_r, 16'h3c5a);
    rx_check(16'h8001, 16'h7ffe);
  endtask
  // Slave mode: the codec drives the clocks; data keeps the same framing.
  task automatic t_slave();
    @(posedge clk_sys_in);
    mst <= 1'b0;
    gen <= 1'b1;
    cl <= 16'h0ff0;
    cr <= 16'hf00f;
    tl <= 16'h0001;
    tr <= 16'h8000;
    frames_wait(3);
    chk("sck_oe_s", 16'(sck_oe), 16'h0000);
    chk("ws_oe_s", 16'(ws_oe), 16'h0000);
    chk("cap_left_s", cap_l, 16'h0001);
    chk("cap_right_s", cap_r, 16'h8000);
    rx_check(16'h0ff0, 16'hf00f);
    gen <= 1'b0;
    en <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    chk("allow_off", 16'(allow), 16'h0001);
    chk("active_off", 16'(act), 16'h0000);
  endtask
  // Main sequence: reset long enough to reach the link domain, then the scenarios.
  initial begin
    repeat (30) @(posedge clk_sys_in);
    chk("ready_rst", 16'(trdy), 16'h0001);
    chk("allow_rst", 16'(allow), 16'h0001);
    srst_in <= 1'b0;
    t_grant();
    t_master();
    t_slave();
    close_out();
  end
endmodule
